// *** core/ucs_core.sv ***
`timescale 1ns/100ps
`default_nettype none
module ucs_core
  import ucs_pkg::*;
(
  input  wire logic        CLK,              // System clock, 100 MHz.
  input  wire logic        RST,              // Asynchronous reset, active high.
  input  wire logic [7:0]  AVS_ADDRESS,      // Byte address of the register word.
  input  wire logic        AVS_READ,         // Read request.
  input  wire logic        AVS_WRITE,        // Write request.
  input  wire logic [31:0] AVS_WRITEDATA,    // Write data.
  input  wire logic [3:0]  AVS_BYTEENABLE,   // Byte lanes of a write.
  output logic [31:0]      AVS_READDATA,     // Read data, registered.
  output logic             AVS_WAITREQUEST,  // Stall until the answer is ready.
  input  wire logic [2:0]  USB_EP,           // Endpoint of the engine's current action.
  input  wire logic        USB_RX_VALID,     // Received byte strobe.
  input  wire logic [7:0]  USB_RX_DATA,      // Received byte.
  input  wire logic        USB_RX_END,       // End of a received packet.
  input  wire logic        USB_RX_SETUP,     // Packet being received is a SETUP.
  input  wire logic        USB_RX_CRC_ERR,   // Packet ended with a CRC error.
  input  wire logic        USB_RX_PID1,      // Packet ended was DATA1.
  input  wire logic        USB_IN_TAKEN,     // Engine took the IN payload.
  input  wire logic        USB_IN_ACKED,     // Host acknowledged the IN payload.
  input  wire logic        USB_HALT_ACKED,   // Host acknowledged a STALL.
  input  wire logic [5:0]  USB_TX_INDEX,     // Byte index of IN payload to fetch.
  output logic [7:0]       USB_TX_DATA,      // Fetched IN byte, one cycle later.
  output logic [6:0]       USB_TX_LEN,       // IN payload length, one cycle later.
  output logic [5:0]       EP_ACCEPT_OUT,    // Endpoint may accept OUT data.
  output logic [5:0]       EP_TX_READY,      // Endpoint has an IN payload waiting.
  output logic [5:0]       EP_HALT,          // Endpoint answers with STALL.
  output logic [5:0]       EP_DIR_IN,        // Control data stage runs IN.
  output logic [5:0]       EP_STATUS_IN      // Control status stage runs IN.
);

  ucs_core_s  s;
  ucs_core_s  next_s;
  ucs_flags_s flags [EP_COUNT];
  ucs_event_s ev [EP_COUNT];
  logic [7:0] mem [MEM_DEPTH];

  logic        bus_req;
  logic        accept;
  logic        hit_csr;
  logic        hit_fdr;
  logic [2:0]  idx;
  logic [15:0] sw_mask;
  logic [5:0]  sw_wr;
  logic [5:0]  rd_bank;
  logic [5:0]  any_rx;
  logic [6:0]  avail [EP_COUNT];
  logic [5:0]  free0;
  logic [5:0]  free_any;
  logic        rx_ep_ok;
  logic [2:0]  e;
  logic        wb;
  logic        pick;
  logic        rx_wen;
  logic [10:0] rx_waddr;
  logic        fw_wen;
  logic [10:0] fw_waddr;

  // Packet memory index of a byte in one region of one endpoint.
  function automatic logic [10:0] mem_addr(input logic [2:0] ep, input logic [1:0] region,
                                           input logic [5:0] pos);
    return 11'(ep) * 11'(REGIONS * BANK_BYTES) + 11'(region) * 11'(BANK_BYTES) + 11'(pos);
  endfunction : mem_addr

  // One flag register per endpoint.
  for (genvar g = 0; g < EP_COUNT; g++) begin : g_ep
    ucs_ep_flags u_flags (
      .CLK     (CLK),
      .RST     (RST),
      .SW_WR   (sw_wr[g]),
      .SW_DATA (ucs_flags_s'(AVS_WRITEDATA[15:0])),
      .SW_MASK (sw_mask),
      .EV      (ev[g]),
      .FLAGS   (flags[g])
    );
  end

  // Per-endpoint view of banks, availability and link permissions.
  always_comb begin
    for (int i = 0; i < EP_COUNT; i++) begin
      any_rx[i]   = flags[i].bank0_received | flags[i].setup_received |
                    flags[i].bank1_received;
      rd_bank[i]  = ~(flags[i].bank0_received | flags[i].setup_received);
      avail[i]    = any_rx[i] ? 7'(s.rx_cnt[i][rd_bank[i]] - s.rx_rd[i][rd_bank[i]]) : 7'h00;
      free0[i]    = ~flags[i].bank0_received & ~flags[i].setup_received;
      free_any[i] = free0[i] | (PINGPONG_EPS[i] & ~flags[i].bank1_received);
      // OUT is refused while halted, disabled, holding a setup or without a bank.
      EP_ACCEPT_OUT[i] = flags[i].endpoint_on_off & ~flags[i].force_halt &
                         ~flags[i].setup_received & free_any[i] &
                         (ucs_is_control(flags[i].endpoint_kind) |
                          ~flags[i].endpoint_kind[2]);
      EP_TX_READY[i]   = flags[i].transmit_ready;
      EP_HALT[i]       = flags[i].force_halt;
      EP_DIR_IN[i]     = flags[i].dir_in;
      EP_STATUS_IN[i]  = ~flags[i].dir_in;
    end
  end

  // Bus decode; one wait state on every request, unmapped words read zero.
  always_comb begin
    bus_req         = AVS_READ | AVS_WRITE;
    AVS_WAITREQUEST = bus_req & ~s.ack;
    accept          = bus_req & s.ack;
    idx             = AVS_ADDRESS[4:2];
    hit_csr = ((AVS_ADDRESS & BLOCK_MASK) == CSR_BASE) && (int'(idx) < EP_COUNT);
    hit_fdr = ((AVS_ADDRESS & BLOCK_MASK) == FDR_BASE) && (int'(idx) < EP_COUNT);
    sw_mask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    sw_wr   = 6'h00;
    if (accept && AVS_WRITE && hit_csr) sw_wr[idx] = 1'b1;
  end

  // Engine event routing to the addressed endpoint.
  always_comb begin
    e        = USB_EP;
    rx_ep_ok = int'(e) < EP_COUNT;
    pick     = (USB_RX_SETUP || free0[e]) ? 1'b0 : 1'b1;
    wb       = (s.rx_wr[e] == 7'h00) ? pick : s.rx_bank[e];
    for (int i = 0; i < EP_COUNT; i++) begin
      ev[i] = '0;
      if (rx_ep_ok && int'(e) == i) begin
        ev[i].in_taken   = USB_IN_TAKEN;
        ev[i].in_acked   = USB_IN_ACKED;
        ev[i].halt_acked = USB_HALT_ACKED;
        ev[i].pid_data1  = USB_RX_PID1;
        if (USB_RX_END && USB_RX_SETUP) begin
          ev[i].setup_stored = 1'b1;
        end else if (USB_RX_END && EP_ACCEPT_OUT[i] &&
                     (!USB_RX_CRC_ERR || ucs_is_iso(flags[i].endpoint_kind))) begin
          ev[i].bank0_stored = ~wb;
          ev[i].bank1_stored = wb;
        end
        ev[i].crc_error = USB_RX_END && USB_RX_CRC_ERR && EP_ACCEPT_OUT[i];
      end
    end
  end

  // Next state: bus answers, FIFO pointers and packet counts.
  always_comb begin
    next_s   = s;
    next_s.ack = 1'b0;
    rx_wen   = 1'b0;
    rx_waddr = '0;
    fw_wen   = 1'b0;
    fw_waddr = '0;
    // First cycle of a request: capture the read value; a write leaves it standing.
    if (bus_req && !s.ack) begin
      next_s.ack = 1'b1;
      if (AVS_READ && hit_csr) begin
        next_s.rdata = {5'h00, 4'h0, avail[idx], 16'(flags[idx])};
      end else if (AVS_READ && hit_fdr && avail[idx] != 7'h00) begin
        next_s.rdata = {24'h000000,
          mem[mem_addr(idx, {1'b0, rd_bank[idx]}, s.rx_rd[idx][rd_bank[idx]][5:0])]};
      end else if (AVS_READ) begin
        next_s.rdata = 32'h00000000;
      end
    end
    // Second cycle: the request takes effect.
    if (accept && AVS_READ && hit_fdr && avail[idx] != 7'h00) begin
      next_s.rx_rd[idx][rd_bank[idx]] = 7'(s.rx_rd[idx][rd_bank[idx]] + 7'h01);
    end
    if (accept && AVS_WRITE && hit_fdr && AVS_BYTEENABLE[0] &&
        !flags[idx].transmit_ready && s.tx_cnt[idx] != 7'(BANK_BYTES)) begin
      fw_wen   = 1'b1;
      fw_waddr = mem_addr(idx, REGION_TX, s.tx_cnt[idx][5:0]);
      next_s.tx_cnt[idx] = 7'(s.tx_cnt[idx] + 7'h01);
    end
    // A released bank empties its pointers.
    for (int i = 0; i < EP_COUNT; i++) begin
      if (sw_wr[i] && AVS_BYTEENABLE[0] &&
          ((flags[i].bank0_received && !AVS_WRITEDATA[POS_BK0]) ||
           (flags[i].setup_received && !AVS_WRITEDATA[POS_SETUP]))) begin
        next_s.rx_cnt[i][0] = 7'h00;
        next_s.rx_rd[i][0]  = 7'h00;
      end
      if (sw_wr[i] && AVS_BYTEENABLE[0] && flags[i].bank1_received &&
          !AVS_WRITEDATA[POS_BK1]) begin
        next_s.rx_cnt[i][1] = 7'h00;
        next_s.rx_rd[i][1]  = 7'h00;
      end
    end
    // Received bytes go to the bank chosen at the first byte.
    if (rx_ep_ok && USB_RX_VALID && (USB_RX_SETUP || EP_ACCEPT_OUT[e]) &&
        s.rx_wr[e] != 7'(BANK_BYTES)) begin
      rx_wen   = 1'b1;
      rx_waddr = mem_addr(e, {1'b0, wb}, s.rx_wr[e][5:0]);
      next_s.rx_wr[e]   = 7'(s.rx_wr[e] + 7'h01);
      next_s.rx_bank[e] = wb;
    end
    // Packet end publishes the count of a stored packet.
    if (rx_ep_ok && USB_RX_END) begin
      if (ev[e].setup_stored || ev[e].bank0_stored || ev[e].bank1_stored) begin
        next_s.rx_cnt[e][wb] = s.rx_wr[e];
        next_s.rx_rd[e][wb]  = 7'h00;
      end
      next_s.rx_wr[e] = 7'h00;
    end
    // The IN payload restarts once the host has it.
    if (rx_ep_ok && USB_IN_ACKED) next_s.tx_cnt[e] = 7'h00;
    // Engine fetch port for the IN payload.
    next_s.tx_data = rx_ep_ok ? mem[mem_addr(e, REGION_TX, USB_TX_INDEX)] : 8'h00;
    next_s.tx_len  = rx_ep_ok ? s.tx_cnt[e] : 7'h00;
  end

  // State register.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Packet memory; engine and firmware write distinct regions.
  always_ff @(posedge CLK) begin
    if (rx_wen) begin
      mem[rx_waddr] <= USB_RX_DATA;
    end
    if (fw_wen) begin
      mem[fw_waddr] <= AVS_WRITEDATA[7:0];
    end
  end

  // Registered outputs.
  always_comb begin
    AVS_READDATA = s.rdata;
    USB_TX_DATA  = s.tx_data;
    USB_TX_LEN   = s.tx_len;
  end

endmodule : ucs_core
`default_nettype wire

// *** core/ucs_ep_flags.sv ***
`timescale 1ns/100ps
`default_nettype none
module ucs_ep_flags
  import ucs_pkg::*;
(
  input  wire logic       CLK,     // System clock.
  input  wire logic       RST,     // Asynchronous reset, active high.
  input  wire logic       SW_WR,   // Accepted firmware write to this word.
  input  wire ucs_flags_s SW_DATA, // Written value.
  input  wire logic [15:0] SW_MASK, // Bits covered by enabled byte lanes.
  input  wire ucs_event_s EV,      // Engine events for this endpoint.
  output ucs_flags_s      FLAGS    // Current flags as firmware reads them.
);

  ucs_flags_s s;
  ucs_flags_s next_s;
  logic [15:0] w;
  logic        iso;

  // Firmware effects first, engine sets last so a set wins over a clear.
  always_comb begin
    next_s = s;
    w      = SW_WR ? SW_MASK : 16'h0000;
    iso    = ucs_is_iso(s.endpoint_kind);
    if (w[POS_TRANSMIT_COMPLETE] && !SW_DATA.transmit_complete) next_s.transmit_complete = 1'b0;
    if (w[POS_BK0] && !SW_DATA.bank0_received) next_s.bank0_received = 1'b0;
    if (w[POS_SETUP] && !SW_DATA.setup_received) next_s.setup_received = 1'b0;
    if (w[POS_HALTACK] && !SW_DATA.halt_acknowledged) begin
      next_s.halt_acknowledged = 1'b0;
    end
    if (w[POS_BK1] && !SW_DATA.bank1_received) next_s.bank1_received = 1'b0;
    if (EV.in_taken) next_s.transmit_ready = 1'b0;
    if (w[POS_TXRDY] && SW_DATA.transmit_ready) next_s.transmit_ready = 1'b1;
    if (w[POS_FHALT]) next_s.force_halt = SW_DATA.force_halt;
    if (w[POS_DIR]) next_s.dir_in = SW_DATA.dir_in;
    if (w[POS_KIND]) next_s.endpoint_kind = SW_DATA.endpoint_kind;
    if (w[POS_ONOFF]) next_s.endpoint_on_off = SW_DATA.endpoint_on_off;
    if (EV.in_acked) begin
      next_s.transmit_complete   = 1'b1;
      next_s.packet_toggle_state = ~s.packet_toggle_state;
    end
    if (EV.bank0_stored) next_s.bank0_received = 1'b1;
    if (EV.bank1_stored) next_s.bank1_received = 1'b1;
    if (EV.setup_stored) next_s.setup_received = 1'b1;
    if (EV.bank0_stored || EV.bank1_stored || EV.setup_stored) begin
      next_s.packet_toggle_state = EV.pid_data1;
    end
    if ((EV.halt_acked && !iso) || (EV.crc_error && iso)) begin
      next_s.halt_acknowledged = 1'b1;
    end
    next_s.rsvd = 3'h0;
  end

  // Flag register; all kinds come up as control.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s <= ucs_flags_s'(CSR_RESET);
    end else begin
      s <= next_s;
    end
  end

  // Control endpoints always read as enabled.
  always_comb begin
    FLAGS = s;
    if (ucs_is_control(s.endpoint_kind)) FLAGS.endpoint_on_off = 1'b1;
  end

endmodule : ucs_ep_flags
`default_nettype wire

// *** core/ucs_pkg.sv ***
package ucs_pkg;

  // Sizes of the endpoint set and its packet memory.
  localparam int EP_COUNT   = 6;
  localparam int BANK_BYTES = 64;
  localparam int REGIONS    = 3;
  localparam int MEM_DEPTH  = EP_COUNT * REGIONS * BANK_BYTES;

  // Register map: control/status words then FIFO data words.
  localparam logic [7:0] BLOCK_MASK = 8'he0;
  localparam logic [7:0] CSR_BASE   = 8'h00;
  localparam logic [7:0] FDR_BASE   = 8'h20;

  // Packet memory regions of one endpoint.
  localparam logic [1:0] REGION_RX0 = 2'h0;
  localparam logic [1:0] REGION_RX1 = 2'h1;
  localparam logic [1:0] REGION_TX  = 2'h2;

  // Endpoints that own a second receive bank.
  localparam logic [5:0] PINGPONG_EPS = 6'h36;

  // Endpoint kind encodings.
  localparam logic [2:0] KIND_CONTROL  = 3'h0;
  localparam logic [2:0] KIND_ISO_OUT  = 3'h1;
  localparam logic [2:0] KIND_ISO_IN   = 3'h5;
  localparam logic [2:0] KIND_BULK_OUT = 3'h2;
  localparam logic [2:0] KIND_BULK_IN  = 3'h6;
  localparam logic [2:0] KIND_INT_OUT  = 3'h3;
  localparam logic [2:0] KIND_INT_IN   = 3'h7;

  // Bit positions inside the control/status word.
  localparam int POS_TRANSMIT_COMPLETE  = 0;
  localparam int POS_BK0     = 1;
  localparam int POS_SETUP   = 2;
  localparam int POS_HALTACK = 3;
  localparam int POS_TXRDY   = 4;
  localparam int POS_FHALT   = 5;
  localparam int POS_BK1     = 6;
  localparam int POS_DIR     = 7;
  localparam int POS_KIND    = 8;
  localparam int POS_TOGGLE  = 11;
  localparam int POS_ONOFF   = 15;
  localparam int POS_COUNT   = 16;
  localparam logic [15:0] CSR_RESET = 16'h0000;

  // Low half of the control/status word, laid out bit for bit.
  typedef struct packed {
    logic       endpoint_on_off;
    logic [2:0] rsvd;
    logic       packet_toggle_state;
    logic [2:0] endpoint_kind;
    logic       dir_in;
    logic       bank1_received;
    logic       force_halt;
    logic       transmit_ready;
    logic       halt_acknowledged;
    logic       setup_received;
    logic       bank0_received;
    logic       transmit_complete;
  } ucs_flags_s;

  // Engine events for one endpoint, each a one-cycle pulse.
  typedef struct packed {
    logic in_taken;
    logic in_acked;
    logic halt_acked;
    logic bank0_stored;
    logic bank1_stored;
    logic setup_stored;
    logic crc_error;
    logic pid_data1;
  } ucs_event_s;

  // Whole state of the core module but the packet memory and the flags.
  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdata;
    logic [7:0]            tx_data;
    logic [6:0]            tx_len;
    logic [5:0][1:0][6:0]  rx_cnt;
    logic [5:0][1:0][6:0]  rx_rd;
    logic [5:0][6:0]       rx_wr;
    logic [5:0]            rx_bank;
    logic [5:0][6:0]       tx_cnt;
  } ucs_core_s;

  // Control endpoints decode from the low kind bits.
  function automatic logic ucs_is_control(input logic [2:0] kind);
    return kind[1:0] == KIND_CONTROL[1:0];
  endfunction : ucs_is_control

  // Isochronous endpoints in either direction.
  function automatic logic ucs_is_iso(input logic [2:0] kind);
    return kind[1:0] == KIND_ISO_OUT[1:0];
  endfunction : ucs_is_iso

endpackage : ucs_pkg

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import ucs_pkg::*;
;
  logic clk, rst, rd, wr, waitreq, rx_v, rx_end, rx_stp, rx_crc, rx_pid, in_tk, in_ack, h_ack;
  logic [7:0]  addr, rx_d, tx_d, b;
  logic [31:0] wdata, rdata, q, w;
  logic [2:0]  ep;
  logic [5:0]  tx_idx, acc, txr, halt, dir_in, st_in;
  logic [6:0]  tx_len;
  logic [2:0]  kinds [7];
  int n_mismatch = 0;
  int comparisons = 0;
  ucs_core uut (.CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .USB_EP(ep), .USB_RX_VALID(rx_v), .USB_RX_DATA(rx_d),
    .USB_RX_END(rx_end), .USB_RX_SETUP(rx_stp), .USB_RX_CRC_ERR(rx_crc), .USB_RX_PID1(rx_pid),
    .USB_IN_TAKEN(in_tk), .USB_IN_ACKED(in_ack), .USB_HALT_ACKED(h_ack), .USB_TX_INDEX(tx_idx),
    .USB_TX_DATA(tx_d), .USB_TX_LEN(tx_len), .EP_ACCEPT_OUT(acc), .EP_TX_READY(txr),
    .EP_HALT(halt), .EP_DIR_IN(dir_in), .EP_STATUS_IN(st_in));
  ucs_host_model host (.clk, .ep, .rx_v, .rx_d, .rx_end, .rx_stp, .rx_crc, .rx_pid, .in_tk,
    .in_ack, .h_ack, .tx_idx, .tx_d, .tx_len, .txr);
  // Compares one result and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One bus transfer held until waitrequest is seen low.
  task automatic bus(input logic w_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w_en;
    rd <= !w_en;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    chk("wait cycles", 32'd2, 32'(n));
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wcsr(input int e, input logic [31:0] d);
    bus(1'b1, CSR_BASE + 8'(4 * e), d);
  endtask : wcsr
  task automatic ccsr(input int e, input logic [31:0] x);
    bus(1'b0, CSR_BASE + 8'(4 * e), 32'h0);
    chk("csr", x, q);
  endtask : ccsr
  task automatic cfifo(input int e, input logic [7:0] x);
    bus(1'b0, FDR_BASE + 8'(4 * e), 32'h0);
    chk("fifo", {24'h0, x}, q);
  endtask : cfifo
  // Prints the verdict and ends the run.
  task automatic wrap_up;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cuts a hang short.
  initial begin
    #300000;
    n_mismatch++;
    $display("ERROR watchdog expected finish seen hang");
    wrap_up();
  end
  // Main sequence of register and engine traffic.
  initial begin
    {rst, addr, rd, wr, wdata} = {1'b1, 8'h00, 2'h0, 32'h0};
    kinds = '{KIND_ISO_OUT, KIND_ISO_IN, KIND_BULK_OUT, KIND_BULK_IN, KIND_INT_OUT,
              KIND_INT_IN, KIND_CONTROL};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int e = 0; e < 6; e++) ccsr(e, 32'h0000_8000);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    for (int i = 0; i < 7; i++) begin
      w = {21'h0, kinds[i], 8'h00};
      wcsr(5, w);
      ccsr(5, (kinds[i] == KIND_CONTROL) ? 32'h8000 : w);
      wcsr(5, w | 32'h8000);
      ccsr(5, w | 32'h8000);
    end
    host.send(0, 8, 8'h10, 1'b1, 1'b0, 1'b0, 0);
    ccsr(0, 32'h0008_8004);
    chk("accept", 32'h0, {31'h0, acc[0]});
    host.send(0, 3, 8'h50, 1'b0, 1'b0, 1'b0, 1);
    wcsr(0, 32'h0000_8004);
    ccsr(0, 32'h0008_8004);
    for (int i = 0; i < 8; i++) cfifo(0, 8'h10 + 8'(i));
    ccsr(0, 32'h0000_8004);
    wcsr(0, 32'h0000_0080);
    ccsr(0, 32'h0000_8080);
    chk("dir", 32'h0, {31'h0, st_in[0] | ~dir_in[0]});
    wcsr(1, 32'h0000_8200);
    host.send(1, 3, 8'h20, 1'b0, 1'b1, 1'b0, 2);
    ccsr(1, 32'h0003_8a02);
    host.send(1, 2, 8'h30, 1'b0, 1'b0, 1'b0, 0);
    ccsr(1, 32'h0003_8242);
    for (int i = 0; i < 3; i++) cfifo(1, 8'h20 + 8'(i));
    wcsr(1, 32'h0000_8240);
    ccsr(1, 32'h0002_8240);
    for (int i = 0; i < 2; i++) cfifo(1, 8'h30 + 8'(i));
    wcsr(1, 32'h0000_8200);
    ccsr(1, 32'h0000_8200);
    wcsr(3, 32'h0000_8600);
    for (int i = 0; i < 4; i++) bus(1'b1, FDR_BASE + 8'h0c, 32'h40 + 32'(i));
    wcsr(3, 32'h0000_8610);
    ccsr(3, 32'h0000_8610);
    bus(1'b1, FDR_BASE + 8'h0c, 32'hee);
    chk("tx ready", 32'h1, {31'h0, txr[3]});
    host.take(3);
    for (int i = 0; i < 4; i++) begin
      host.fetch(3, i, b, tx_len);
      chk("in byte", 32'h40 + 32'(i), {24'h0, b});
    end
    chk("in length", 32'd4, {25'h0, tx_len});
    ccsr(3, 32'h0000_8600);
    host.ack(3, 1'b0);
    ccsr(3, 32'h0000_8e01);
    wcsr(3, 32'h0000_8e01);
    ccsr(3, 32'h0000_8e01);
    wcsr(3, 32'h0000_8620);
    ccsr(3, 32'h0000_8e20);
    chk("halt", 32'h1, {31'h0, halt[3]});
    host.ack(3, 1'b1);
    ccsr(3, 32'h0000_8e28);
    wcsr(3, 32'h0000_8600);
    ccsr(3, 32'h0000_8e00);
    chk("halt", 32'h0, {31'h0, halt[3]});
    wcsr(4, 32'h0000_8100);
    host.ack(4, 1'b1);
    ccsr(4, 32'h0000_8100);
    host.send(4, 2, 8'h60, 1'b0, 1'b0, 1'b1, 0);
    ccsr(4, 32'h0002_810a);
    wcsr(4, 32'h0000_8100);
    ccsr(4, 32'h0000_8100);
    wrap_up();
  end
endmodule : tb_top
bind ucs_core ucs_core_properties u_prop (.CLK, .RST, .AVS_READ, .AVS_WRITE, .AVS_READDATA,
  .AVS_WAITREQUEST, .USB_EP, .USB_RX_END, .USB_RX_SETUP, .USB_IN_TAKEN, .EP_ACCEPT_OUT,
  .EP_TX_READY, .EP_HALT, .EP_DIR_IN, .EP_STATUS_IN);
`default_nettype wire

// *** tb/ucs_core_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module ucs_core_properties (
  input wire logic        CLK,             // System clock.
  input wire logic        RST,             // Asynchronous reset.
  input wire logic        AVS_READ,        // Read request.
  input wire logic        AVS_WRITE,       // Write request.
  input wire logic [31:0] AVS_READDATA,    // Read data.
  input wire logic        AVS_WAITREQUEST, // Bus stall.
  input wire logic [2:0]  USB_EP,          // Engine endpoint.
  input wire logic        USB_RX_END,      // Packet end.
  input wire logic        USB_RX_SETUP,    // SETUP packet.
  input wire logic        USB_IN_TAKEN,    // IN payload taken.
  input wire logic [5:0]  EP_ACCEPT_OUT,   // OUT allowed.
  input wire logic [5:0]  EP_TX_READY,     // IN payload waiting.
  input wire logic [5:0]  EP_HALT,         // STALL answer.
  input wire logic [5:0]  EP_DIR_IN,       // Data stage IN.
  input wire logic [5:0]  EP_STATUS_IN     // Status stage IN.
);
  logic req;
  logic wr_done;
  logic [5:0] tx_rise;
  // Every check samples on the system clock and rests during reset.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Helpers for a pending request and an accepted write.
  assign req = AVS_READ || AVS_WRITE;
  assign wr_done = AVS_WRITE && !AVS_WAITREQUEST;
  always_ff @(posedge CLK) begin
    tx_rise <= EP_TX_READY;
  end
  property p_one_wait;
    req && !$past(req) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus answer not after exactly one wait state");
  property p_rdata_stands;
    !$past(AVS_READ) |-> $stable(AVS_READDATA);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands)
    else $error("read data moved without a read");
  property p_setup_blocks_out;
    USB_RX_END && USB_RX_SETUP && USB_EP < 3'h6 |=> !EP_ACCEPT_OUT[$past(USB_EP)];
  endproperty
  a_setup_blocks_out: assert property (p_setup_blocks_out)
    else $error("OUT still accepted after a SETUP");
  property p_taken_clears;
    USB_IN_TAKEN && USB_EP < 3'h6 |=> !EP_TX_READY[$past(USB_EP)];
  endproperty
  a_taken_clears: assert property (p_taken_clears)
    else $error("transmit ready kept after IN taken");
  property p_ready_by_write;
    (EP_TX_READY & ~tx_rise) != 6'h00 |-> $past(wr_done);
  endproperty
  a_ready_by_write: assert property (p_ready_by_write)
    else $error("transmit ready rose without a write");
  property p_halt_by_write;
    $changed(EP_HALT) |-> $past(wr_done);
  endproperty
  a_halt_by_write: assert property (p_halt_by_write)
    else $error("halt changed without a write");
  property p_dir_by_write;
    $changed(EP_DIR_IN) |-> $past(wr_done);
  endproperty
  a_dir_by_write: assert property (p_dir_by_write)
    else $error("direction changed without a write");
  property p_status_rev;
    EP_STATUS_IN == ~EP_DIR_IN;
  endproperty
  a_status_rev: assert property (p_status_rev)
    else $error("status stage not reversed");
endmodule : ucs_core_properties
`default_nettype wire

// *** tb/ucs_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ucs_host_model
  import ucs_pkg::*;
(
  input  wire logic       clk,    // System clock.
  output logic [2:0]      ep,     // Endpoint addressed.
  output logic            rx_v,   // Byte strobe.
  output logic [7:0]      rx_d,   // Byte.
  output logic            rx_end, // Packet end.
  output logic            rx_stp, // SETUP packet.
  output logic            rx_crc, // CRC error.
  output logic            rx_pid, // DATA1 packet.
  output logic            in_tk,  // IN payload taken.
  output logic            in_ack, // Host acknowledged IN.
  output logic            h_ack,  // Host acknowledged STALL.
  output logic [5:0]      tx_idx, // IN byte index.
  input  wire logic [7:0] tx_d,   // IN byte.
  input  wire logic [6:0] tx_len, // IN length.
  input  wire logic [5:0] txr     // IN payload waiting.
);
  // The line is idle at time zero.
  initial begin
    {ep, rx_v, rx_d, rx_end, rx_stp, rx_crc, rx_pid, in_tk, in_ack, h_ack, tx_idx} = '0;
  end
  // Sends a packet of n bytes from b0 upward; gap idles slow the host down.
  task automatic send(input logic [2:0] e, input int n, input logic [7:0] b0,
                      input logic stp, input logic pid, input logic crc, input int gap);
    @(posedge clk);
    ep <= e;
    rx_stp <= stp;
    for (int i = 0; i < n; i++) begin
      rx_v <= 1'b1;
      rx_d <= b0 + 8'(i);
      @(posedge clk);
      if (gap > 0) begin
        rx_v <= 1'b0;
        rx_d <= ~rx_d;
        repeat (gap) @(posedge clk);
      end
    end
    rx_v <= 1'b0;
    rx_d <= ~rx_d;
    rx_end <= 1'b1;
    rx_pid <= pid;
    rx_crc <= crc;
    @(posedge clk);
    {rx_end, rx_stp, rx_pid, rx_crc} <= 4'h0;
  endtask : send
  // Takes an IN payload only while one waits.
  task automatic take(input logic [2:0] e);
    @(posedge clk);
    ep <= e;
    in_tk <= txr[e];
    @(posedge clk);
    in_tk <= 1'b0;
  endtask : take
  // One acknowledge pulse: IN data, or a STALL when halt_ev is high.
  task automatic ack(input logic [2:0] e, input logic halt_ev);
    @(posedge clk);
    ep <= e;
    in_ack <= !halt_ev;
    h_ack <= halt_ev;
    @(posedge clk);
    {in_ack, h_ack} <= 2'h0;
  endtask : ack
  // Fetches one IN byte; the answer is registered one cycle late.
  task automatic fetch(input logic [2:0] e, input int i, output logic [7:0] d,
                       output logic [6:0] len);
    @(posedge clk);
    ep <= e;
    tx_idx <= 6'(i);
    repeat (2) @(posedge clk);
    d = tx_d;
    len = tx_len;
  endtask : fetch
endmodule : ucs_host_model
`default_nettype wire
